// *** rtl/arming_pkg.sv ***
// arming and density-modulated output constants, modes and state carriers
// assumes a single 25 MHz clock; samples arrive already offset-cancelled
// Behaviour
// - density output only when configuration selects it
// - saturate sample to 10 bits, unsigned
// - 10 MHz accumulator carry drives density pin
// - arming only under SPI, three modes
// - after fault, stretch runs, no updates
// - moving average over last k samples
// - sample at slave-select fall, data response, source zero
// - average past threshold arms and loads stretch
// - stretched modes release at expiry, or at once when SPI or the armed mode is left
// - count increments on hit, clears otherwise
// - count reaching limit arms and loads stretch
// - unfiltered compares latest sample each edge
// - unfiltered pin follows data response, unstretched
// - down-sample counter gates evaluation at zero
// - stretch select zero follows last evaluation
// - nonzero stretch select follows timer only
// - timer decrements, reloads on arming condition
// - arming pin polarity selectable
package arming_pkg;
	localparam int          CLK_HZ           = 25000000;
	localparam int          DSM_HZ           = 10000000;
	// phase step: 10 MHz out of 25 MHz is 2 out of 5
	localparam logic [2:0]  DSM_NUM          = 3'h2;
	localparam logic [2:0]  DSM_DEN          = 3'h5;
	localparam int          SAMPLE_W         = 16;
	localparam int          DSM_W            = 10;
	localparam logic signed [15:0] DSM_MAX   = 16'sh01ff;
	localparam logic signed [15:0] DSM_MIN   = -16'sh0200;
	localparam int          TICK_US          = 1;
	localparam int          TICK_CYC         = (CLK_HZ / 1000000) * TICK_US;
	localparam int          STRETCH_W        = 8;
	localparam int          WIN_MAX          = 8;
	localparam logic [1:0]  DS_RESET         = 2'h0;
	localparam logic [7:0]  STRETCH_RESET    = 8'h00;

	// configuration field encodings
	typedef enum logic [2:0]
	{
		CFG_OFF       = 3'h0,
		CFG_AVG       = 3'h1,
		CFG_COUNT     = 3'h2,
		CFG_UNFILT    = 3'h3,
		CFG_DENSITY   = 3'h4
	} arm_cfg_type;

	typedef struct packed
	{
		arm_cfg_type            mode;
		logic                   active_low;
		logic [1:0]             arming_window_size;
		logic [1:0]             arming_downsample_select;
		logic [1:0]             arming_stretch_select;
		logic [STRETCH_W-1:0]   stretch_value;
		logic signed [15:0]     pos_threshold;
		logic signed [15:0]     neg_threshold;
	} arm_config_type;
endpackage

// *** rtl/density_modulator.sv ***
// first-order density modulator: 10-bit accumulator whose carry drives the pin
// assumes a 25 MHz clock; the 10 MHz rate is made by a fractional enable
`timescale 1ns/1ns
module density_modulator
	import arming_pkg::*;
(
	input  wire logic                  ref_clk_i,   // system clock
	input  wire logic                  rst_n_i,     // async reset, low
	input  wire logic                  enable_i,    // density output selected
	input  wire logic signed [15:0]    sample_i,    // signed sample
	output logic                       pcm_o        // carry output
);
	typedef struct packed
	{
		logic [2:0]        phase;
		logic [DSM_W-1:0]  acc;
		logic              carry;
	} dsm_state_type;

	dsm_state_type  st_reg;
	dsm_state_type  st_next;
	logic [DSM_W-1:0] unsigned_smp;
	logic [DSM_W:0]   sum;
	logic [3:0]       phase_sum;

	// saturate and offset to unsigned
	always_comb
	begin
		if (sample_i > DSM_MAX)
			unsigned_smp = 10'h3ff;
		else if (sample_i < DSM_MIN)
			unsigned_smp = 10'h000;
		else
			unsigned_smp = {~sample_i[9], sample_i[8:0]};
		sum = {1'b0, st_reg.acc} + {1'b0, unsigned_smp};
		phase_sum = {1'b0, st_reg.phase} + {1'b0, DSM_NUM};
	end

	// accumulator steps at 10 MHz average rate
	always_comb
	begin
		st_next = st_reg;
		if (!enable_i)
		begin
			st_next = '0;
		end
		else if (phase_sum >= {1'b0, DSM_DEN})
		begin
			st_next.phase = 3'(phase_sum - {1'b0, DSM_DEN});
			st_next.acc   = sum[DSM_W-1:0];
			st_next.carry = sum[DSM_W];
		end
		else
		begin
			st_next.phase = phase_sum[2:0];
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign pcm_o = st_reg.carry;

	AST_DSM_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!enable_i |=> !pcm_o) else $error("density pin active while disabled");
endmodule

// *** rtl/sensor_arming_logic.sv ***
// arming decision for one channel, plus the optional density output
// assumes slave select and response flags come from pins; sample is same-clock logic
`timescale 1ns/1ns
module sensor_arming_logic
	import arming_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC    // stretch decrement period in clocks
)
(
	input  wire logic                  ref_clk_i,       // 25 MHz clock
	input  wire logic                  rst_n_i,         // async reset, low
	input  wire arm_config_type        cfg_i,           // channel configuration
	input  wire logic                  spi_selected_i,  // interface is SPI
	input  wire logic                  fault_i,         // error or exception
	input  wire logic signed [15:0]    sample_i,        // offset-cancelled sample
	input  wire logic                  ss_n_i,          // slave select pin, low
	input  wire logic                  data_resp_i,     // pin: sensor-data response
	input  wire logic                  src_zero_i,      // pin: source identifier zero
	output logic                       arm_o,           // arming pin
	output logic                       arm_cond_o,      // last evaluation armed
	output logic                       pcm_o            // density output pin
);
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_FROZE = 3'b100
	} phase_type;

	typedef struct packed
	{
		logic [1:0]                     ss_sync;
		logic [1:0]                     resp_sync;
		logic [1:0]                     src_sync;
		logic                           ss_prev;
		phase_type                      phase;
		logic [WIN_MAX*SAMPLE_W-1:0]    hist;
		logic [1:0]                     ds_cnt;
		logic [3:0]                     hit_cnt;
		logic                           cond;
		logic [STRETCH_W-1:0]           stretch;
		logic [15:0]                    tick;
		logic                           pin;
	} arm_state_type;

	arm_state_type  st_reg;
	arm_state_type  st_next;

	logic                   ss_fall;
	logic                   qualify;
	logic                   arm_on;
	logic [3:0]             k;
	logic signed [19:0]     sum;
	logic signed [15:0]     avg;
	logic                   avg_hit;
	logic                   smp_hit;
	logic                   stretched;
	logic [SAMPLE_W-1:0]    win [WIN_MAX];

	// window size maps to 1, 2, 4 or 8 samples or counts
	assign k = 4'(1 << cfg_i.arming_window_size);
	assign arm_on = spi_selected_i && (cfg_i.mode == CFG_AVG || cfg_i.mode == CFG_COUNT
		|| cfg_i.mode == CFG_UNFILT);
	assign stretched = (cfg_i.mode != CFG_UNFILT) && (cfg_i.arming_stretch_select != 2'h0);

	// edge on the synchronised slave select, qualified by data response and source zero
	assign ss_fall = st_reg.ss_prev && !st_reg.ss_sync[1];
	assign qualify = ss_fall && st_reg.resp_sync[1] && st_reg.src_sync[1];

	// unpack the history window
	genvar gi;
	generate
		for (gi = 0; gi < WIN_MAX; gi++)
		begin : g_win
			assign win[gi] = st_reg.hist[gi*SAMPLE_W +: SAMPLE_W];
		end
	endgenerate

	// average over the newest k samples, sample included
	always_comb
	begin
		sum = 20'(sample_i);
		for (int i = 0; i < WIN_MAX - 1; i++)
			if (4'(i + 1) < k)
				sum = sum + 20'($signed(win[i]));
		avg = 16'(sum >>> cfg_i.arming_window_size);
		avg_hit = (avg >= cfg_i.pos_threshold) || (avg <= cfg_i.neg_threshold);
		smp_hit = (sample_i >= cfg_i.pos_threshold)
			|| (sample_i <= cfg_i.neg_threshold);
	end

	// main next-state logic
	always_comb
	begin
		logic new_cond;
		logic evaluate;
		new_cond = 1'b0;
		evaluate = 1'b0;
		st_next = st_reg;
		st_next.ss_sync   = {st_reg.ss_sync[0], ss_n_i};
		st_next.resp_sync = {st_reg.resp_sync[0], data_resp_i};
		st_next.src_sync  = {st_reg.src_sync[0], src_zero_i};
		st_next.ss_prev   = st_reg.ss_sync[1];

		// stretch timer ticks down to zero
		if (st_reg.tick >= 16'(TICK_CYCLES - 1))
		begin
			st_next.tick = 16'h0000;
			if (st_reg.stretch != '0)
				st_next.stretch = st_reg.stretch - 1'b1;
		end
		else
		begin
			st_next.tick = st_reg.tick + 16'h0001;
		end

		case (st_reg.phase)
			ST_IDLE:
			begin
				if (arm_on)
					st_next.phase = ST_RUN;
			end
			ST_RUN:
			begin
				if (!arm_on)
				begin
					st_next.phase = ST_IDLE;
					st_next.cond = 1'b0;
					st_next.hit_cnt = 4'h0;
					st_next.ds_cnt = DS_RESET;
				end
				else if (fault_i)
				begin
					st_next.phase = ST_FROZE;
				end
				else if (qualify)
				begin
					// down-sampling gate
					evaluate = (st_reg.ds_cnt == 2'h0) || (cfg_i.mode == CFG_UNFILT);
					if (st_reg.ds_cnt >= cfg_i.arming_downsample_select)
						st_next.ds_cnt = 2'h0;
					else
						st_next.ds_cnt = st_reg.ds_cnt + 2'h1;
				end
			end
			ST_FROZE:
			begin
				// no update; stretch keeps running down
				if (!fault_i || !arm_on)
					st_next.phase = arm_on ? ST_RUN : ST_IDLE;
			end
			default:
			begin
				st_next.phase = ST_IDLE;
			end
		endcase

		if (evaluate)
		begin
			case (cfg_i.mode)
				CFG_AVG:
				begin
					st_next.hist = {st_reg.hist[(WIN_MAX-1)*SAMPLE_W-1:0], sample_i};
					new_cond = avg_hit;
				end
				CFG_COUNT:
				begin
					if (smp_hit)
					begin
						if (st_reg.hit_cnt < 4'hf)
							st_next.hit_cnt = st_reg.hit_cnt + 4'h1;
					end
					else
					begin
						st_next.hit_cnt = 4'h0;
					end
					// compare without adding, so a saturated count cannot wrap
					new_cond = smp_hit && (st_reg.hit_cnt >= (k - 4'h1));
				end
				CFG_UNFILT:
				begin
					new_cond = smp_hit;
				end
				default:
				begin
					new_cond = 1'b0;
				end
			endcase
			st_next.cond = new_cond;
			if (new_cond && cfg_i.mode != CFG_UNFILT)
				st_next.stretch = cfg_i.stretch_value;
		end

		// arming pin level before polarity
		if (cfg_i.mode == CFG_UNFILT)
			st_next.pin = st_next.cond && !st_reg.ss_sync[1] && st_reg.resp_sync[1];
		else if (stretched)
			st_next.pin = (st_next.stretch != '0);
		else
			st_next.pin = st_next.cond;
		if (!arm_on)
			st_next.pin = 1'b0;
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_reg <= '0;
			st_reg.ss_sync <= 2'h3;
			st_reg.ss_prev <= 1'b1;
			st_reg.phase <= ST_IDLE;
			st_reg.ds_cnt <= DS_RESET;
			st_reg.stretch <= STRETCH_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign arm_o = st_reg.pin ^ cfg_i.active_low;
	assign arm_cond_o = st_reg.cond;

	// density output path
	density_modulator u_dsm
	(
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.enable_i  (cfg_i.mode == CFG_DENSITY),
		.sample_i  (sample_i),
		.pcm_o     (pcm_o)
	);

	sequence s_freeze;
		st_reg.phase == ST_FROZE;
	endsequence

	AST_FROZEN_NO_UPDATE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_freeze |=> $stable(st_reg.cond)) else $error("evaluation changed while frozen");
	AST_NO_ARM_OFF_SPI: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!spi_selected_i |=> !st_reg.pin) else $error("arming without spi");
	AST_STRETCH_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == ST_RUN && !fault_i && qualify && st_reg.ds_cnt == 2'h0
		&& cfg_i.mode == CFG_AVG && avg_hit && arm_on)
		|=> st_reg.stretch == $past(cfg_i.stretch_value)) else $error("stretch not loaded");
	AST_STRETCH_PIN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(stretched && arm_on) |=> (st_reg.pin == (st_reg.stretch != '0)) || !$past(stretched))
		else $error("pin not following timer");
	AST_COUNT_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == ST_RUN && arm_on && !fault_i && qualify && st_reg.ds_cnt == 2'h0
		&& cfg_i.mode == CFG_COUNT && !smp_hit) |=> st_reg.hit_cnt == 4'h0)
		else $error("count not cleared");
	AST_DS_GATE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == ST_RUN && arm_on && !fault_i && qualify && st_reg.ds_cnt != 2'h0
		&& cfg_i.mode != CFG_UNFILT) |=> $stable(st_reg.cond)) else $error("skipped sample used");
	AST_STRETCH_DECAY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_reg.stretch == '0 && !qualify) |=> st_reg.stretch == '0)
		else $error("timer rose without load");
	AST_POLARITY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		arm_o == (st_reg.pin ^ cfg_i.active_low)) else $error("polarity wrong");
	AST_UNFILT_PIN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(cfg_i.mode == CFG_UNFILT && st_reg.ss_sync[1]) |=> !st_reg.pin)
		else $error("unfiltered pin outside frame");

	// qualified sample that the down-sampling gate lets through
	sequence s_eval;
		st_reg.phase == ST_RUN && arm_on && !fault_i && qualify
		&& (st_reg.ds_cnt == 2'h0 || cfg_i.mode == CFG_UNFILT);
	endsequence

	// qualified sample seen while running, gate not yet applied
	sequence s_qual;
		st_reg.phase == ST_RUN && arm_on && !fault_i && qualify;
	endsequence

	// unfiltered and average results follow the compare of that cycle
	AST_UNFILT_COND: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_eval ##0 (cfg_i.mode == CFG_UNFILT) |=> st_reg.cond == $past(smp_hit))
		else $error("unfiltered condition wrong");
	AST_AVG_COND: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_eval ##0 (cfg_i.mode == CFG_AVG) |=> st_reg.cond == $past(avg_hit))
		else $error("average condition wrong");

	// count mode steps and limit
	AST_COUNT_INC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_eval ##0 (cfg_i.mode == CFG_COUNT && smp_hit && st_reg.hit_cnt != 4'hf)
		|=> st_reg.hit_cnt == $past(st_reg.hit_cnt) + 4'h1)
		else $error("count not incremented");
	AST_COUNT_ARM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_eval ##0 (cfg_i.mode == CFG_COUNT && smp_hit && st_reg.hit_cnt >= (k - 4'h1))
		|=> st_reg.cond) else $error("count limit did not arm");

	// leaving the armed modes while running clears the evaluation
	AST_OFF_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == ST_RUN && !arm_on) |=> !st_reg.cond)
		else $error("condition kept after disarm");

	// unstretched pin follows the last evaluation
	AST_PLAIN_PIN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(arm_on && !stretched && cfg_i.mode != CFG_UNFILT) |=> st_reg.pin == st_reg.cond)
		else $error("pin not following evaluation");

	// a fault freezes evaluation but lets the timer run without reload
	AST_FREEZE_ENTRY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == ST_RUN && arm_on && fault_i) |=> st_reg.phase == ST_FROZE)
		else $error("fault did not freeze");
	AST_FROZEN_STRETCH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(s_freeze ##0 (st_reg.tick < 16'(TICK_CYCLES - 1)))
		|=> st_reg.stretch == $past(st_reg.stretch))
		else $error("timer reloaded while frozen");

	// down-sampling counter wraps at the selected maximum
	AST_DS_WRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_qual ##0 (st_reg.ds_cnt >= cfg_i.arming_downsample_select)
		|=> st_reg.ds_cnt == 2'h0) else $error("down-sample counter did not wrap");

	// timer drops by one on each tick when nothing reloads it
	AST_TICK_DEC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_reg.stretch != '0 && st_reg.tick >= 16'(TICK_CYCLES - 1) && !qualify)
		|=> st_reg.stretch == $past(st_reg.stretch) - 8'h01)
		else $error("timer did not decrement");
endmodule

// *** testbench/spi_host_model.sv ***
// spi host model: issues one frame per request, sensor data or not as resp_i says
// assumes the bench clock; frames keep the host minimum spacing
`timescale 1ns/1ns
module spi_host_model
#(
	parameter int LEN = 8,   // clocks with slave select low
	parameter int GAP = 6    // idle clocks after a frame
)
(
	input  wire logic ref_clk_i,  // clock
	input  wire logic go_i,       // frame request
	input  wire logic resp_i,     // frame is sensor data
	input  wire logic src_i,      // frame is source zero
	output logic      ss_n_o,     // slave select, low
	output logic      resp_o,     // data response pin
	output logic      src_o       // source zero pin
);
	// idle levels
	initial
	begin
		ss_n_o = 1'b1;
		resp_o = 1'b0;
		src_o = 1'b0;
	end

	// frame, then released pins and enforced gap
	always @(posedge ref_clk_i)
	begin
		if (go_i)
		begin
			#1;
			ss_n_o = 1'b0;
			resp_o = resp_i;
			src_o = src_i;
			repeat (LEN) @(posedge ref_clk_i);
			#1;
			ss_n_o = 1'b1;
			resp_o = ~resp_o; // released: not the last value
			src_o = ~src_o;
			repeat (GAP) @(posedge ref_clk_i);
		end
	end
endmodule

// *** testbench/test_sensor_arming_logic.sv ***
// testbench: corner and random frames against the arming block
// assumes the package, design and host model compile first
`timescale 1ns/1ns
module test_sensor_arming_logic import arming_pkg::*;;
	logic               ref_clk_i = 1'b0;
	logic               rst_n_i = 1'b0;
	arm_config_type     cfg = '0;
	logic               spi = 1'b1;
	logic               fault = 1'b0;
	logic signed [15:0] sample = '0;
	logic               go = 1'b0;
	logic               r_q = 1'b0;
	logic               z_q = 1'b0;
	logic               ss_n;
	logic               resp;
	logic               src0;
	logic               arm_o;
	logic               cond;
	logic               pcm;
	logic               exp = 1'b0;
	logic               warm = 1'b1;
	logic               mid_arm;
	logic signed [15:0] hist [8] = '{default: '0};
	logic signed [15:0] corner [4] = '{16'sh0400, 16'sh03ff, -16'sh0400, -16'sh03ff};
	logic signed [15:0] ds_tab [4] = '{16'sh0000, 16'sh0500, 16'sh0500, 16'sh0000};
	logic signed [15:0] dens [4] = '{16'sh7fff, 16'sh0000, -16'sh8000, 16'sh0100};
	int                 cnt = 0;
	int                 ds_cnt = 0;
	int                 seed = 71;
	int                 mismatches = 0;
	int                 tests_run = 0;
	int                 n;
	int                 dph = 0;
	time                t_load;

	sensor_arming_logic #(.TICK_CYCLES(2)) DUT
	(
		.ref_clk_i      (ref_clk_i),
		.rst_n_i        (rst_n_i),
		.cfg_i          (cfg),
		.spi_selected_i (spi),
		.fault_i        (fault),
		.sample_i       (sample),
		.ss_n_i         (ss_n),
		.data_resp_i    (resp),
		.src_zero_i     (src0),
		.arm_o          (arm_o),
		.arm_cond_o     (cond),
		.pcm_o          (pcm)
	);

	spi_host_model host
	(
		.ref_clk_i (ref_clk_i),
		.go_i      (go),
		.resp_i    (r_q),
		.src_i     (z_q),
		.ss_n_o    (ss_n),
		.resp_o    (resp),
		.src_o     (src0)
	);

	// 25 MHz clock
	always #20 ref_clk_i = ~ref_clk_i;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic seen, input logic want);
		tests_run++;
		if (seen !== want)
		begin
			mismatches++;
			$display("Error at %0t: seen %b expected %b", $time, seen, want);
		end
	endtask

	function automatic logic hit(input logic signed [15:0] v);
		return v >= cfg.pos_threshold || v <= cfg.neg_threshold;
	endfunction

	// reference evaluation for average and count modes
	function automatic logic model(input logic signed [15:0] s);
		int sum;
		int k;
		k = 1 << cfg.arming_window_size;
		for (int i = 7; i > 0; i--)
			hist[i] = hist[i - 1];
		hist[0] = s;
		sum = 0;
		for (int i = 0; i < k; i++)
			sum += hist[i];
		cnt = hit(s) ? cnt + 1 : 0;
		if (cfg.mode == CFG_AVG)
			return hit(16'(sum >>> cfg.arming_window_size));
		return cnt >= k;
	endfunction

	function automatic int duty(input logic signed [15:0] s);
		int v;
		v = (s > 511) ? 511 : (s < -512) ? -512 : int'(s);
		return (v + 512) * 200 / 1024;
	endfunction

	// one host frame, expectation update and checks
	task automatic frame(input logic signed [15:0] s, input logic r, input logic z);
		sample = s;
		r_q = r;
		z_q = z;
		go = 1'b1;
		@(posedge ref_clk_i);
		#1;
		go = 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1;
		mid_arm = arm_o;
		repeat (9) @(posedge ref_clk_i);
		#1;
		if (r && z && spi && !fault && cfg.mode == CFG_UNFILT)
			exp = hit(s);
		else if (r && z && spi && !fault && cfg.mode inside {CFG_AVG, CFG_COUNT})
		begin
			if (ds_cnt == 0)
				exp = model(s);
			ds_cnt = (ds_cnt == cfg.arming_downsample_select) ? 0 : ds_cnt + 1;
		end
		else if (!spi || cfg.mode inside {CFG_OFF, CFG_DENSITY})
			exp = 1'b0;
		if (warm)
		begin
			check(cond, exp);
			if (cfg.mode == CFG_UNFILT)
			begin
				check(mid_arm, exp ^ cfg.active_low);
				check(arm_o, cfg.active_low);
			end
			else if (cfg.arming_stretch_select == 2'h0)
				check(arm_o, exp ^ cfg.active_low);
		end
	endtask

	// counts density carries once per 10 MHz step, 200 steps after 8 to settle
	task automatic pcm_run(input logic signed [15:0] s, input int want);
		int ones;
		int steps;
		sample = s;
		ones = 0;
		steps = 0;
		repeat (520)
		begin
			@(posedge ref_clk_i);
			#1;
			dph = dph + int'(DSM_NUM);
			if (dph >= int'(DSM_DEN))
			begin
				dph = dph - int'(DSM_DEN);
				if (steps >= 8 && steps < 208)
					ones += (pcm === 1'b1) ? 1 : 0;
				steps++;
			end
		end
		check(ones >= want - 1 && ones <= want + 1, 1'b1);
	endtask

	// watchdog
	initial
	begin
		#(40 * 20000);
		mismatches++;
		finish_test();
	end

	// main sequence
	initial
	begin
		cfg.pos_threshold = 16'sh0400;
		cfg.neg_threshold = -16'sh0400;
		repeat (12) @(posedge ref_clk_i);
		check(arm_o, 1'b0);
		check(cond, 1'b0);
		check(pcm, 1'b0);
		#1;
		rst_n_i = 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		cfg.mode = CFG_UNFILT;
		foreach (corner[i])
			frame(corner[i], 1'b1, 1'b1);
		frame(16'sh0500, 1'b1, 1'b0);
		frame(16'sh0500, 1'b0, 1'b1);
		for (int j = 0; j < 2; j++)
		begin
			cfg.mode = (j == 0) ? CFG_AVG : CFG_COUNT;
			for (int i = 0; i < 32; i++)
			begin
				warm = (i >= 8);
				if (i % 8 == 0)
					cfg.arming_window_size = 2'($random(seed));
				cfg.active_low = 1'($random(seed));
				frame((i == 0) ? 16'sh0000 : 16'($random(seed) % 2048), 1'b1, 1'b1);
			end
		end
		cfg.arming_window_size = 2'h0;
		cfg.arming_downsample_select = 2'h1;
		foreach (ds_tab[i])
			frame(ds_tab[i], 1'b1, 1'b1);
		cfg.arming_downsample_select = 2'h0;
		spi = 1'b0;
		frame(16'sh0500, 1'b1, 1'b1);
		spi = 1'b1;
		cfg.arming_stretch_select = 2'h1;
		cfg.stretch_value = 8'h05;
		frame(16'sh0500, 1'b1, 1'b1);
		check(mid_arm, ~cfg.active_low);
		check(arm_o, cfg.active_low);
		cfg.stretch_value = 8'hff;
		t_load = $time;
		frame(16'sh0500, 1'b1, 1'b1);
		fault = 1'b1;
		frame(16'sh0000, 1'b1, 1'b1);
		frame(16'sh0500, 1'b1, 1'b1);
		n = 0;
		while (arm_o !== cfg.active_low && n < 1000)
		begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		n = int'(($time - t_load) / 40);
		check(n > 505 && n < 525, 1'b1);
		fault = 1'b0;
		frame(16'sh0000, 1'b1, 1'b1);
		dph = 0;
		cfg.mode = CFG_DENSITY;
		foreach (dens[i])
			pcm_run(dens[i], duty(dens[i]));
		cfg.mode = CFG_OFF;
		pcm_run(16'sh7fff, 0);
		finish_test();
	end
endmodule
